// [rtl/cfg_load_regs.svh]
// register offsets, field positions, reset values and timing counts
// assumes a 10 MHz system clock and a plain word-wide register port
`ifndef CFG_LOAD_REGS_SVH
`define CFG_LOAD_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define REG_CTRL_ADDR 4'h0
`define REG_LENGTH_ADDR 4'h4
`define REG_STATUS_ADDR 4'h8

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define CTRL_WIDTH_LSB 0
`define CTRL_RATIO_LSB 4
`define CTRL_USRCLK_BIT 8
`define CTRL_RESET 9'h010
`define LENGTH_RESET 20'h00001
`define STAT_STATE_LSB 0
`define STAT_DRIVE_BIT 4
`define STAT_DONE_BIT 5
`define STAT_USER_BIT 6
`define STAT_PIN_BIT 7
`define STAT_REQ_BIT 8

// ----------------------------------------------------------------------
// timing, in printed units, and derived cycle counts
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define T_CF2ST0_NS 600
`define CF2ST0_CYC (`T_CF2ST0_NS / `CLK_PERIOD_NS)
`define T_STATUS_MIN_US 268
`define STATUS_MIN_CYC ((`T_STATUS_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_STATUS_MAX_US 1506
`define STATUS_MAX_CYC ((`T_STATUS_MAX_US * 1000) / `CLK_PERIOD_NS)
`define T_INIT_MIN_US 175
`define INIT_MIN_CYC ((`T_INIT_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_INIT_MAX_US 437
`define INIT_MAX_CYC ((`T_INIT_MAX_US * 1000) / `CLK_PERIOD_NS)
`define LOAD_CLK_MAX_PERIOD_NS 8
`define T_CD2CU_NS (4 * `LOAD_CLK_MAX_PERIOD_NS)
`define CD2CU_RAW ((`T_CD2CU_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CD2CU_CYC ((`CD2CU_RAW < 1) ? 1 : `CD2CU_RAW)
`define USR_INIT_EDGES 8576

`endif

// [rtl/cfg_load_pkg.sv]
// types shared by the load sequencer files
// assumes nothing beyond a SystemVerilog compiler
package cfg_load_pkg;

  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_CLEAR,
    ST_EXT_HOLD,
    ST_LOADING,
    ST_INIT_OSC,
    ST_INIT_DELAY,
    ST_INIT_USR,
    ST_USER
  } seq_state_e;

  // data bus width modes
  typedef enum logic [1:0] {
    WIDTH_8,
    WIDTH_16,
    WIDTH_32
  } bus_width_e;

endpackage

// [rtl/load_capture.sv]
// link-side word capture, clocked by the host's load clock
// assumes width, ratio and length stay still while the link is armed
`timescale 1ns/10ps
module load_capture (
  // link clock and reset
  input wire logic load_clk,
  input wire logic link_rst_n,
  // settings, static while armed
  input wire logic [1:0] width_sel,
  input wire logic [3:0] ratio,
  input wire logic [19:0] length,
  // image data from the host
  input wire logic [31:0] load_data,
  // captured stream and completion
  output logic [31:0] word,
  output logic word_valid,
  output logic image_full
);

  logic [3:0] phase_ff;
  logic [19:0] count_ff;
  logic [31:0] word_ff;
  logic valid_ff;
  logic full_ff;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  function automatic logic [31:0] width_mask(input logic [1:0] sel, input logic [31:0] d);
    case (sel)
      cfg_load_pkg::WIDTH_8: width_mask = {24'h000000, d[7:0]};
      cfg_load_pkg::WIDTH_16: width_mask = {16'h0000, d[15:0]};
      default: width_mask = d;
    endcase
  endfunction

  // ratio zero behaves as one
  wire [3:0] last_phase = (ratio == 4'h0) ? 4'h0 : ratio - 4'h1;
  // one word per ratio edges, none once the image is complete
  wire capture = ~full_ff & (phase_ff == 4'h0); // [RULE10] [RULE11] [RULE15]
  wire [19:0] nxt_count = count_ff + 20'h00001;
  wire [3:0] nxt_phase = (full_ff || phase_ff == last_phase) ? 4'h0 : phase_ff + 4'h1;

  // capture registers
  always_ff @(posedge load_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      phase_ff <= 4'h0;
      count_ff <= 20'h00000;
      word_ff <= 32'h00000000;
      valid_ff <= 1'b0;
      full_ff <= 1'b0;
    end
    else
    begin
      phase_ff <= nxt_phase;
      valid_ff <= capture;
      if (capture)
      begin
        count_ff <= nxt_count;
        word_ff <= width_mask(width_sel, load_data);
        full_ff <= (nxt_count >= length);
      end
    end
  end

  assign word = word_ff;
  assign word_valid = valid_ff;
  assign image_full = full_ff;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge load_clk); endclocking
  default disable iff (!link_rst_n);

  chk_ratio_one_each: assert property ( // [RULE10]
    (ratio == 4'h1 && !full_ff) |=> (count_ff == $past(count_ff) + 20'h00001 && word_valid))
    else $error("ratio one edge did not take a word");

  chk_ratio_hold_gap: assert property ( // [RULE11]
    (ratio > 4'h1 && capture) |=> (!capture && word_valid) ##1 !word_valid)
    else $error("word taken again inside the hold periods");

endmodule

// [rtl/parallel_config_load_sequencer.sv]
// configuration load sequencer: request, status and done handshake,
// parallel word capture on the load clock, and entry into user mode
// assumes an open-drain status wire resolved outside, a host that keeps
// the load clock still until the status line has risen
//
// Notes on behaviour
// [RULE1] In user mode request, status and done are high, and a low request starts a new cycle.
// [RULE2] Done falls within 600 ns of the request falling.
// [RULE3] The status line is pulled low within 600 ns of the request falling.
// [RULE4] The host holds the request low for at least 2 us.
// [RULE5] Status stays low from 268 us up to 1,506 us unless the host stretches it.
// [RULE6] Status is released within 1,506 us of the request rising unless held low outside.
// [RULE7] A host watching status waits 2 us after it rises before the first load clock edge.
// [RULE8] A host not watching status waits 1,506 us after the request rises before clocking.
// [RULE9] The load clock stays at or below 125 MHz for 8 or 16 bits and 100 MHz for 32 bits.
// [RULE10] With ratio one every rising load clock edge takes one new word.
// [RULE11] With ratio N above one a word is held for N-1 more periods after its capture edge.
// [RULE12] With the internal oscillator user mode follows done by 175 us to 437 us.
// [RULE13] With the user init clock the host enables it no sooner than four load clock periods.
// [RULE14] With the user init clock user mode comes no sooner than that delay plus 8576 edges.
// [RULE15] The host sends words on successive capture edges and clocks until done rises.
`timescale 1ns/10ps
`include "cfg_load_regs.svh"
module parallel_config_load_sequencer #(
  parameter logic [15:0] STATUS_MAX_CYC = 16'(`STATUS_MAX_CYC),
  parameter logic [15:0] INIT_MAX_CYC = 16'(`INIT_MAX_CYC),
  parameter logic [15:0] USR_EDGES = 16'(`USR_INIT_EDGES)
) (
  // system clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // configuration handshake pins
  input wire logic CONFIG_REQUEST_N,
  input wire logic LOAD_STATUS_N_IN,
  output logic LOAD_STATUS_N_OUT,
  output logic LOAD_STATUS_N_OE,
  output logic LOAD_COMPLETE,
  // load link
  input wire logic LOAD_CLOCK,
  input wire logic [31:0] LOAD_DATA,
  output logic [31:0] LOAD_WORD,
  output logic LOAD_WORD_VALID,
  // initialization
  input wire logic USER_INIT_CLK,
  output logic USER_MODE
);

  localparam logic [15:0] STATUS_LAST_C = 16'(`STATUS_MIN_CYC - 1);
  localparam logic [15:0] INIT_LAST_C = 16'(`INIT_MIN_CYC - 1);
  localparam logic [15:0] CD2CU_LAST_C = 16'(`CD2CU_CYC - 1);
  localparam logic [15:0] STATUS_MIN_C = 16'(`STATUS_MIN_CYC);
  localparam logic [15:0] INIT_MIN_C = 16'(`INIT_MIN_CYC);
  localparam logic [15:0] CD2CU_C = 16'(`CD2CU_CYC);

  cfg_load_pkg::seq_state_e state_ff;
  cfg_load_pkg::seq_state_e nxt_state;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic req_meta_ff;
  logic req_sync_ff;
  logic stat_meta_ff;
  logic stat_sync_ff;
  logic full_meta_ff;
  logic full_sync_ff;
  logic uclk_meta_ff;
  logic uclk_sync_ff;
  logic uclk_prev_ff;
  logic drive_ff;
  logic done_ff;
  logic user_ff;
  logic arm_ff;
  logic [8:0] ctrl_ff;
  logic [19:0] length_ff;
  logic [31:0] rdata_ff;
  logic image_full;

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  // pins and the link-side completion level pass two flops
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      req_meta_ff <= 1'b1;
      req_sync_ff <= 1'b1;
      stat_meta_ff <= 1'b0;
      stat_sync_ff <= 1'b0;
      full_meta_ff <= 1'b0;
      full_sync_ff <= 1'b0;
      uclk_meta_ff <= 1'b0;
      uclk_sync_ff <= 1'b0;
      uclk_prev_ff <= 1'b0;
    end
    else
    begin
      req_meta_ff <= CONFIG_REQUEST_N;
      req_sync_ff <= req_meta_ff;
      stat_meta_ff <= LOAD_STATUS_N_IN;
      stat_sync_ff <= stat_meta_ff;
      full_meta_ff <= image_full;
      full_sync_ff <= full_meta_ff;
      uclk_meta_ff <= USER_INIT_CLK;
      uclk_sync_ff <= uclk_meta_ff;
      uclk_prev_ff <= uclk_sync_ff;
    end
  end

  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  // decode and read selection
  wire wr_ctrl = REG_WR && (REG_ADDR == `REG_CTRL_ADDR);
  wire wr_length = REG_WR && (REG_ADDR == `REG_LENGTH_ADDR);
  wire usr_opt = ctrl_ff[`CTRL_USRCLK_BIT];
  wire [1:0] width_sel = ctrl_ff[`CTRL_WIDTH_LSB +: 2];
  wire [3:0] ratio = ctrl_ff[`CTRL_RATIO_LSB +: 4];
  wire [31:0] status_word = {23'h000000, req_sync_ff, stat_sync_ff, user_ff, done_ff,
                             drive_ff, 1'b0, state_ff};
  wire [31:0] rd_mux = (REG_ADDR == `REG_CTRL_ADDR) ? {23'h000000, ctrl_ff} :
                       (REG_ADDR == `REG_LENGTH_ADDR) ? {12'h000, length_ff} :
                       (REG_ADDR == `REG_STATUS_ADDR) ? status_word : 32'h00000000;

  // settings and one-cycle read data
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ctrl_ff <= `CTRL_RESET;
      length_ff <= `LENGTH_RESET;
      rdata_ff <= 32'h00000000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_ff <= REG_WDATA[8:0];
      if (wr_length)
        length_ff <= REG_WDATA[19:0];
      rdata_ff <= REG_RD ? rd_mux : 32'h00000000;
    end
  end

  assign REG_RDATA = rdata_ff;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  function automatic logic reached(input logic [15:0] cnt, input logic [15:0] target);
    reached = (cnt >= target);
  endfunction

  // next state; a low request overrides every state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      cfg_load_pkg::ST_CLEAR:
        // held low while the request is low and until the least width has passed since entry
        if (req_sync_ff && reached(cnt_ff, STATUS_LAST_C)) // [RULE4] [RULE5] [RULE6]
          nxt_state = cfg_load_pkg::ST_EXT_HOLD;
      cfg_load_pkg::ST_EXT_HOLD:
        // wait while someone outside keeps status low
        if (stat_sync_ff) // [RULE6]
          nxt_state = cfg_load_pkg::ST_LOADING;
      cfg_load_pkg::ST_LOADING:
        if (full_sync_ff)
          nxt_state = usr_opt ? cfg_load_pkg::ST_INIT_DELAY : cfg_load_pkg::ST_INIT_OSC;
      cfg_load_pkg::ST_INIT_OSC:
        if (reached(cnt_ff, INIT_LAST_C)) // [RULE12]
          nxt_state = cfg_load_pkg::ST_USER;
      cfg_load_pkg::ST_INIT_DELAY:
        if (reached(cnt_ff, CD2CU_LAST_C)) // [RULE13] [RULE14]
          nxt_state = cfg_load_pkg::ST_INIT_USR;
      cfg_load_pkg::ST_INIT_USR:
        if (reached(cnt_ff, USR_EDGES)) // [RULE14]
          nxt_state = cfg_load_pkg::ST_USER;
      cfg_load_pkg::ST_USER:
        nxt_state = cfg_load_pkg::ST_USER;
      default:
        nxt_state = cfg_load_pkg::ST_CLEAR;
    endcase
    if (!req_sync_ff) // [RULE1]
      nxt_state = cfg_load_pkg::ST_CLEAR;
  end

  // state timer, counts user clock edges in the user clock phase
  wire uclk_rise = uclk_sync_ff & ~uclk_prev_ff;
  wire cnt_step = (state_ff == cfg_load_pkg::ST_INIT_USR) ? uclk_rise : 1'b1;
  wire cnt_hold = (cnt_ff == 16'hFFFF) || !cnt_step;
  assign nxt_cnt = (nxt_state != state_ff) ? 16'h0000 :
                   cnt_hold ? cnt_ff : cnt_ff + 16'h0001;

  // pin levels follow the next state so they move with it
  wire nxt_drive = (nxt_state == cfg_load_pkg::ST_CLEAR); // [RULE3]
  wire nxt_done = (nxt_state == cfg_load_pkg::ST_INIT_OSC) ||
                  (nxt_state == cfg_load_pkg::ST_INIT_DELAY) ||
                  (nxt_state == cfg_load_pkg::ST_INIT_USR) ||
                  (nxt_state == cfg_load_pkg::ST_USER); // [RULE2]
  wire nxt_user = (nxt_state == cfg_load_pkg::ST_USER); // [RULE1]
  // link is armed only once status has been seen high
  wire nxt_arm = !nxt_drive && (nxt_state != cfg_load_pkg::ST_EXT_HOLD); // [RULE7] [RULE8]

  // state and output flops; power-up holds status low
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_ff <= cfg_load_pkg::ST_CLEAR;
      cnt_ff <= 16'h0000;
      drive_ff <= 1'b1;
      done_ff <= 1'b0;
      user_ff <= 1'b0;
      arm_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      drive_ff <= nxt_drive;
      done_ff <= nxt_done;
      user_ff <= nxt_user;
      arm_ff <= nxt_arm;
    end
  end

  assign LOAD_STATUS_N_OUT = 1'b0;
  assign LOAD_STATUS_N_OE = drive_ff;
  assign LOAD_COMPLETE = done_ff;
  assign USER_MODE = user_ff;

  // ----------------------------------------------------------------------
  // link side
  // ----------------------------------------------------------------------
  // link logic is cleared while disarmed; the load clock is still then
  wire link_rst_n = RESET_N & arm_ff; // [RULE7] [RULE8]

  load_capture u_capture (
    .load_clk(LOAD_CLOCK),
    .link_rst_n(link_rst_n),
    .width_sel(width_sel),
    .ratio(ratio),
    .length(length_ff),
    .load_data(LOAD_DATA),
    .word(LOAD_WORD),
    .word_valid(LOAD_WORD_VALID),
    .image_full(image_full)
  );

  // ----------------------------------------------------------------------
  // check helpers
  // ----------------------------------------------------------------------
  logic [15:0] low_cnt_ff;
  logic [15:0] rel_cnt_ff;
  logic [15:0] done_cnt_ff;
  logic [15:0] uedge_cnt_ff;
  wire init_phase = done_ff && !user_ff;

  // time status is driven, time since request rose, time since done
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      low_cnt_ff <= 16'h0000;
      rel_cnt_ff <= 16'h0000;
      done_cnt_ff <= 16'h0000;
      uedge_cnt_ff <= 16'h0000;
    end
    else
    begin
      low_cnt_ff <= drive_ff ? low_cnt_ff + 16'h0001 : 16'h0000;
      rel_cnt_ff <= (drive_ff && req_sync_ff) ? rel_cnt_ff + 16'h0001 : 16'h0000;
      done_cnt_ff <= init_phase ? done_cnt_ff + 16'h0001 : 16'h0000;
      if (!init_phase)
        uedge_cnt_ff <= 16'h0000;
      else if (uclk_rise)
        uedge_cnt_ff <= uedge_cnt_ff + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  chk_user_restart: assert property ( // [RULE1]
    (USER_MODE && !req_sync_ff) |=> (!USER_MODE && LOAD_STATUS_N_OE))
    else $error("low request in user mode did not restart");

  chk_user_levels: assert property ( // [RULE1]
    USER_MODE |-> (LOAD_COMPLETE && !LOAD_STATUS_N_OE))
    else $error("user mode with status or done low");

  chk_done_drops: assert property ( // [RULE2]
    $fell(req_meta_ff) |-> ##2 !LOAD_COMPLETE)
    else $error("done not low in time after request fell");

  chk_status_pulls: assert property ( // [RULE3]
    $fell(req_meta_ff) |-> ##2 (LOAD_STATUS_N_OE && !LOAD_STATUS_N_OUT))
    else $error("status not pulled low in time after request fell");

  chk_status_min_width: assert property ( // [RULE5]
    $fell(LOAD_STATUS_N_OE) |-> (low_cnt_ff >= STATUS_MIN_C))
    else $error("status released before its least low time");

  chk_status_release_bound: assert property ( // [RULE6]
    rel_cnt_ff <= STATUS_MAX_CYC)
    else $error("status still driven too long after request rose");

  chk_init_osc_window: assert property ( // [RULE12]
    ($rose(USER_MODE) && $past(state_ff) == cfg_load_pkg::ST_INIT_OSC)
      |-> (done_cnt_ff >= INIT_MIN_C && done_cnt_ff <= INIT_MAX_CYC))
    else $error("oscillator init time out of window");

  chk_init_usr_edges: assert property ( // [RULE14]
    ($rose(USER_MODE) && $past(state_ff) == cfg_load_pkg::ST_INIT_USR)
      |-> (uedge_cnt_ff >= USR_EDGES && done_cnt_ff > CD2CU_C))
    else $error("user clock init ended too early");

endmodule

// [sim/cfg_host.sv]
// host model for the load sequencer: request pin, status pull-up, link, user clock
// assumes the bench drives req_n, hold and usr_en and calls send_word
`timescale 1ns/10ps
module cfg_host (
  // device drive of the status wire
  input wire logic oe,
  input wire logic od_val,
  // host side pins
  output logic req_n,
  output logic status_n,
  output logic load_clk,
  output logic [31:0] load_data,
  output logic usr_clk
);
  logic hold = 1'b0;
  logic usr_en = 1'b0;

  initial
  begin
    req_n = 1'b1;
    load_clk = 1'b0;
    load_data = 32'h00000000;
    usr_clk = 1'b0;
  end

  // open-drain status wire with pull-up, host may hold it low
  assign status_n = ((oe && !od_val) || hold) ? 1'b0 : 1'b1;

  // user init clock, 500 ns period, parked low while disabled
  always #250 usr_clk = usr_en & ~usr_clk;

  // one word held for n load clock periods of 64 ns, clock still otherwise
  task automatic send_word(input logic [31:0] w, input int n);
    load_data = w;
    repeat (n)
    begin
      #32 load_clk = 1'b1;
      #32 load_clk = 1'b0;
    end
  endtask

  // released data lines flip so no stale word survives
  task automatic park();
    load_data = ~load_data;
  endtask
endmodule

// [sim/tb.sv]
// self-checking bench for the configuration load sequencer
// assumes cfg_host as far-side host and a 10 MHz reference clock
`timescale 1ns/10ps
module tb;
  logic ref_clk, reset_n, reg_wr, reg_rd, req_n, st_in, st_out, st_oe;
  logic done, user_mode, load_clk, usr_clk, load_valid;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, load_data, load_word, d;
  logic [31:0] seed = 32'h0000769C;
  logic [31:0] exp_q[$];
  int fails = 0;
  int n_tests = 0;
  time t_rq1, t_st0, t_st1, t_cd1, t_um;

  parallel_config_load_sequencer #(.USR_EDGES(16'h0010)) DUT (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CONFIG_REQUEST_N(req_n),
    .LOAD_STATUS_N_IN(st_in), .LOAD_STATUS_N_OUT(st_out), .LOAD_STATUS_N_OE(st_oe),
    .LOAD_COMPLETE(done), .LOAD_CLOCK(load_clk), .LOAD_DATA(load_data),
    .LOAD_WORD(load_word), .LOAD_WORD_VALID(load_valid), .USER_INIT_CLK(usr_clk),
    .USER_MODE(user_mode));

  cfg_host host (.oe(st_oe), .od_val(st_out), .req_n(req_n), .status_n(st_in),
    .load_clk(load_clk), .load_data(load_data), .usr_clk(usr_clk));

  // reference clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // edge time stamps of the handshake pins
  always @(posedge req_n) t_rq1 = $time;
  always @(negedge st_in) t_st0 = $time;
  always @(posedge st_in) t_st1 = $time;
  always @(posedge done) t_cd1 = $time;
  always @(posedge user_mode) t_um = $time;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_in(input string what, input longint v, input longint lo, input longint hi);
    check(what, {31'h0, v >= lo && v <= hi}, 32'h00000001);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  function automatic logic [31:0] mask_of(input logic [1:0] w);
    return (w == 2'h0) ? 32'h000000FF : (w == 2'h1) ? 32'h0000FFFF : 32'hFFFFFFFF;
  endfunction

  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // captured words against what the host sent
  always @(negedge load_clk)
    if (load_valid === 1'b1)
      check("captured word", load_word, exp_q.size() ? exp_q.pop_front() : 32'hDEADBEEF);

  // one configuration cycle: request pulse, status, image, initialization
  task automatic run_cfg(input logic [1:0] w, input logic [3:0] r, input int len,
    input logic usr, input int stretch, input int hold, input logic abort, input logic blind);
    int k;
    int n;
    n = (r == 4'h0) ? 1 : int'(r);
    if (stretch > 0)
    begin
      @(posedge ref_clk);
      host.req_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      #90 check("status low after request", st_in, 32'h0);
      check("done after request", {done, user_mode}, 32'h0);
      repeat (stretch - 5) @(posedge ref_clk);
      host.req_n <= 1'b1;
      // outside hold in place before the device lets go of status
      host.hold <= (hold > 0);
    end
    reg_write(4'h0, {23'h0, usr, r, 2'h0, w});
    reg_write(4'h4, 32'(len));
    if (hold > 0)
    begin
      repeat (hold) @(posedge ref_clk);
      reg_read(4'h8, d);
      check("held state", d[2:0], 32'h1);
      host.hold <= 1'b0;
    end
    for (k = 0; k < 20000 && st_in !== 1'b1; k++) settle();
    check_in("status low width", t_st1 - t_st0, 268000,
      (stretch > 100 || hold > 0) ? 2000000 : 1506000);
    check_in("request to status", t_st1 - t_rq1, 0, hold > 0 ? 2000000 : 1506000);
    // a host blind to status times its first edge from the request instead
    if (blind)
      while ($time < t_rq1 + 1506000) settle();
    else
      repeat (20) @(posedge ref_clk);
    for (k = 0; k < (abort ? len / 2 : len); k++)
    begin
      seed = lfsr(seed);
      exp_q.push_back(seed & mask_of(w));
      if (k == len - 1)
        check("early done", done, 32'h0);
      host.send_word(seed, n);
    end
    if (abort)
      return;
    for (k = 0; k < 40 && done !== 1'b1; k++) host.send_word(~seed, 1);
    host.park();
    check("words left", exp_q.size(), 32'h0);
    if (usr)
    begin
      repeat (10) @(posedge ref_clk);
      host.usr_en <= 1'b1;
    end
    for (k = 0; k < 5000 && user_mode !== 1'b1; k++) settle();
    if (usr)
      check_in("user clock init", t_um - t_cd1, 8032, 13000);
    else
      check_in("oscillator init", t_um - t_cd1, 175000, 437000);
    host.usr_en <= 1'b0;
    check("user mode pins", {req_n, st_in, done, user_mode, st_oe}, 32'h1E);
  endtask

  // watchdog, about two and a half times the expected run
  initial
  begin
    repeat (80000) @(posedge ref_clk);
    fails++;
    results();
  end

  // main sequence: reset, registers, then a table of load cycles
  initial
  begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    reg_read(4'h0, d);
    check("control reset", d, 32'h00000010);
    reg_read(4'h4, d);
    check("length reset", d, 32'h00000001);
    reg_write(4'h8, 32'hFFFFFFFF);
    reg_read(4'h8, d);
    check("status reset", d[6:0], 32'h10);
    reg_read(4'hC, d);
    check("unmapped read", d, 32'h0);
    settle();
    check("read data idle", reg_rdata, 32'h0);
    run_cfg(2'h0, 4'h1, 5, 1'b0, 0, 0, 1'b0, 1'b0);
    run_cfg(2'h1, 4'h3, 4, 1'b1, 20, 0, 1'b0, 1'b0);
    run_cfg(2'h2, 4'h2, 6, 1'b0, 20, 0, 1'b1, 1'b0);
    run_cfg(2'h3, 4'h0, 3, 1'b1, 3000, 3000, 1'b0, 1'b0);
    run_cfg(seed[1:0], 4'(seed[5:4]) + 4'h1, 2 + int'(seed[9:8]), seed[12], 20, 0, 1'b0,
      1'b1);
    results();
  end
endmodule
